// file: logic/pmx_defines.vh
/*
  constants for the control pin and port mux block: mode codes, port bit
  positions and the clock divider figure.
  assumes inclusion by bare name from the design file.
*/
`ifndef PMX_DEFINES_VH
`define PMX_DEFINES_VH

// operating modes, {~mode_select_b, mode_select_a} taken as a 2-bit code
`define PMX_MODE_SINGLE   2'h0
`define PMX_MODE_EXPANDED 2'h1
`define PMX_MODE_BOOT     2'h2
`define PMX_MODE_TEST     2'h3

// mode held after reset until the pins are caught (single-chip)
`define PMX_MODE_RST      2'h0

// bus clock is osc clock divided by this figure
`define PMX_ECLK_DIV      4
`define PMX_ECLK_HALF     2'h2

// port d bit positions
`define PMX_PD_RXD        0
`define PMX_PD_TXD        1
`define PMX_PD_MISO       2
`define PMX_PD_MOSI       3
`define PMX_PD_SCK        4
`define PMX_PD_SS         5
`define PMX_PD_STRB       6
`define PMX_PD_DIR        7

// port a bit positions
`define PMX_PA_CMP_LO     4
`define PMX_PA_PULSE      7

// reset value of the irq edge select bit: level sensitive
`define PMX_IRQ_EDGE_SELECT_BIT_RST      1'b0

`endif

// file: logic/pmx_pin_mux.v
/*
  control pins and port muxing of an 8-bit microcontroller: reset pin,
  bus clock divider, interrupt input conditioning, mode latch, fetch
  indicator, timer sharing on port a and mode dependent selection of ports b to d.
  assumes core_clk is the oscillator clock, the cpu core supplies bus
  cycle signals and register values, and the pad ring resolves the
  open-drain and two-way pins from the enables given here.
*/
// Overview of operation
// - the reset pin resets the block and is pulled low while a clock monitor or watchdog fault is flagged.
// - the bus clock is made and driven out at one quarter of the oscillator rate.
// - software may switch off the bus clock pin while in single-chip mode.
// - the maskable interrupt is falling-edge or low-level detected by a select bit that is level after reset.
// - during prom programming the maskable interrupt pin acts as active-low chip enable.
// - the non-maskable input is level sensitive and its mask bit is set during reset until software clears it.
// - the two mode pins are caught as reset releases and pick one of four modes.
// - the fetch indicator is driven low for exactly the first bus clock cycle of each instruction.
// - the direction pin is port d bit 7 in single-chip and boot, and the transfer direction otherwise.
// - the strobe pin is port d bit 6 in single-chip and boot, and the address strobe otherwise.
// - in expanded and test modes port c carries the low address then the data byte, split by the strobe.
// - four 8-bit ports; b, c and d fully two-way; port a has two two-way, three in and three out lines.
// - ports b, c and the two bus bits of d are general io only in single-chip and boot modes.
// - in expanded and test modes port b carries address bits 8 to 15 in order.
// - b high a low single-chip, both high expanded, both low boot, b low a high test.
`timescale 1ns/1ps
`include "pmx_defines.vh"

module pmx_pin_mux (
  input  wire       core_clk,
  input  wire       arst_n,
  // reset pin and fault sources
  input  wire       reset_pin_in_n,
  output wire       reset_pin_oe,
  input  wire       clk_mon_fail,
  input  wire       watchdog_fail,
  output wire       sys_rst_n,
  // bus clock
  output reg        eclk_pin,
  output wire       eclk_rise,
  output wire       eclk_fall,
  input  wire       eclk_off_req,
  // interrupts
  input  wire       irq_pin_n,
  input  wire       irq_edge_select_bit,
  input  wire       irq_ack,
  output reg        irq_req,
  input  wire       prog_active,
  output reg        prom_ce_n,
  input  wire       nonmaskable_int_pin,
  input  wire       x_mask_clear,
  output reg        nonmaskable_int_pin_req,
  output reg        x_mask_q,
  // modes
  input  wire       mode_select_a,
  input  wire       mode_select_b,
  output reg  [1:0] mode_q,
  // fetch indicator
  input  wire       instr_first_cycle,
  output wire       instr_fetch_indicator_oe,
  // bus cycle from the core
  input  wire [15:0] bus_addr,
  input  wire        bus_read,
  input  wire [7:0]  bus_wdata,
  output reg  [7:0]  bus_rdata,
  // port a
  input  wire [7:0] pa_in,
  output reg  [7:0] pa_out,
  output reg  [7:0] pa_oe,
  input  wire [7:0] pa_gpio_out,
  input  wire [1:0] pa_gpio_dir,
  input  wire [4:0] tmr_cmp_out,
  input  wire [4:0] tmr_cmp_en,
  output reg  [3:0] tmr_capture_in,
  output reg        pulse_count_input,
  // port b
  input  wire [7:0] pb_in,
  output reg  [7:0] pb_out,
  output reg  [7:0] pb_oe,
  input  wire [7:0] pb_gpio_out,
  input  wire [7:0] pb_gpio_dir,
  output reg  [7:0] pb_gpio_in,
  // port c
  input  wire [7:0] pc_in,
  output reg  [7:0] pc_out,
  output reg  [7:0] pc_oe,
  input  wire [7:0] pc_gpio_out,
  input  wire [7:0] pc_gpio_dir,
  output reg  [7:0] pc_gpio_in,
  // port d
  input  wire [7:0] pd_in,
  output reg  [7:0] pd_out,
  output reg  [7:0] pd_oe,
  input  wire [7:0] pd_gpio_out,
  input  wire [7:0] pd_gpio_dir,
  output reg  [7:0] pd_gpio_in,
  input  wire [5:0] ser_out,
  input  wire [5:0] ser_oe,
  output reg  [5:0] ser_in
);

  // true when the pins belong to the external bus
  function is_bus_mode;
    input [1:0] m;
    begin
      is_bus_mode = (m == `PMX_MODE_EXPANDED) || (m == `PMX_MODE_TEST);
    end
  endfunction

  // three-stage synchroniser for async pins; change counts when 2 and 3 agree
  reg [2:0] rst_s_q, irq_s_q, nonmaskable_int_pin_s_q, ma_s_q, mb_s_q;
  reg [7:0] pa_s1_q, pa_s2_q, pa_s3_q;
  reg [7:0] pb_s1_q, pb_s2_q, pb_s3_q;
  reg [7:0] pc_s1_q, pc_s2_q, pc_s3_q;
  reg [7:0] pd_s1_q, pd_s2_q, pd_s3_q;
  reg       rst_f_q, irq_f_q, nonmaskable_int_pin_f_q, ma_f_q, mb_f_q;
  reg [7:0] pa_f_q, pb_f_q, pc_f_q, pd_f_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s_q  <= 3'h0;
      irq_s_q  <= 3'h7;
      nonmaskable_int_pin_s_q <= 3'h7;
      ma_s_q   <= 3'h0;
      mb_s_q   <= 3'h7;
      rst_f_q  <= 1'b0;
      irq_f_q  <= 1'b1;
      nonmaskable_int_pin_f_q <= 1'b1;
      ma_f_q   <= 1'b0;
      mb_f_q   <= 1'b1;
      {pa_s1_q, pa_s2_q, pa_s3_q, pa_f_q} <= 32'h0;
      {pb_s1_q, pb_s2_q, pb_s3_q, pb_f_q} <= 32'h0;
      {pc_s1_q, pc_s2_q, pc_s3_q, pc_f_q} <= 32'h0;
      {pd_s1_q, pd_s2_q, pd_s3_q, pd_f_q} <= 32'h0;
    end else begin
      rst_s_q  <= {rst_s_q[1:0], reset_pin_in_n};
      irq_s_q  <= {irq_s_q[1:0], irq_pin_n};
      nonmaskable_int_pin_s_q <= {nonmaskable_int_pin_s_q[1:0], nonmaskable_int_pin};
      ma_s_q   <= {ma_s_q[1:0], mode_select_a};
      mb_s_q   <= {mb_s_q[1:0], mode_select_b};
      if (rst_s_q[1] == rst_s_q[2]) rst_f_q <= rst_s_q[2];
      if (irq_s_q[1] == irq_s_q[2]) irq_f_q <= irq_s_q[2];
      if (nonmaskable_int_pin_s_q[1] == nonmaskable_int_pin_s_q[2]) nonmaskable_int_pin_f_q <= nonmaskable_int_pin_s_q[2];
      if (ma_s_q[1] == ma_s_q[2]) ma_f_q <= ma_s_q[2];
      if (mb_s_q[1] == mb_s_q[2]) mb_f_q <= mb_s_q[2];
      pa_s1_q <= pa_in;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      pa_f_q  <= (pa_s2_q & pa_s3_q) | (pa_f_q & (pa_s2_q | pa_s3_q));
      pb_s1_q <= pb_in;
      pb_s2_q <= pb_s1_q;
      pb_s3_q <= pb_s2_q;
      pb_f_q  <= (pb_s2_q & pb_s3_q) | (pb_f_q & (pb_s2_q | pb_s3_q));
      pc_s1_q <= pc_in;
      pc_s2_q <= pc_s1_q;
      pc_s3_q <= pc_s2_q;
      pc_f_q  <= (pc_s2_q & pc_s3_q) | (pc_f_q & (pc_s2_q | pc_s3_q));
      pd_s1_q <= pd_in;
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      pd_f_q  <= (pd_s2_q & pd_s3_q) | (pd_f_q & (pd_s2_q | pd_s3_q));
    end
  end

  // pin reset merged with the async reset; faults pull the pin low
  assign sys_rst_n    = arst_n & rst_f_q;
  assign reset_pin_oe = clk_mon_fail | watchdog_fail;

  // release edge of the filtered reset: mode pins are caught here
  reg rst_f_d1_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_f_d1_q <= 1'b0;
      mode_q     <= `PMX_MODE_RST;
    end else begin
      rst_f_d1_q <= rst_f_q;
      if (rst_f_q && !rst_f_d1_q) begin
        mode_q <= {~mb_f_q, ma_f_q};
      end
    end
  end

  wire bus_mode = is_bus_mode(mode_q);

  // divide by four: counter phase 0..1 low, 2..3 high
  reg [1:0] div_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q    <= 2'h0;
      eclk_pin <= 1'b0;
    end else begin
      div_q    <= div_q + 2'h1;
      // stopping the pin only in single-chip; the internal phase keeps running
      eclk_pin <= (div_q + 2'h1 >= `PMX_ECLK_HALF) &&
                  !(eclk_off_req && mode_q == `PMX_MODE_SINGLE);
    end
  end
  assign eclk_rise = (div_q == 2'h1);
  assign eclk_fall = (div_q == 2'h3);

  // maskable interrupt: level by default, falling edge if selected
  reg irq_prev_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_prev_q <= 1'b1;
      irq_req    <= 1'b0;
      prom_ce_n  <= 1'b1;
    end else begin
      irq_prev_q <= irq_f_q;
      prom_ce_n  <= prog_active ? irq_f_q : 1'b1;
      if (!irq_edge_select_bit) begin
        irq_req <= ~irq_f_q;
      end else if (irq_prev_q && !irq_f_q) begin
        irq_req <= 1'b1;                                // set wins over ack
      end else if (irq_ack) begin
        irq_req <= 1'b0;
      end
    end
  end

  // non-maskable: level sensitive, masked from reset until software clears
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      x_mask_q <= 1'b1;
      nonmaskable_int_pin_req <= 1'b0;
    end else begin
      if (!sys_rst_n) x_mask_q <= 1'b1;
      else if (x_mask_clear) x_mask_q <= 1'b0;
      nonmaskable_int_pin_req <= ~nonmaskable_int_pin_f_q & ~x_mask_q & sys_rst_n;
    end
  end

  // fetch indicator follows the first bus cycle, cleared while reset is active
  reg lir_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) lir_q <= 1'b0;
    else if (!sys_rst_n) lir_q <= 1'b0;
    else if (div_q == 2'h3) lir_q <= instr_first_cycle;
  end
  assign instr_fetch_indicator_oe = lir_q;

  // phases are judged one edge ahead so the registered pins line up with
  // eclk_pin: address while the bus clock is low, data while it is high
  wire addr_phase = (div_q == 2'h3) || (div_q == 2'h0);

  // port mux, all outputs from flops
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pa_out <= 8'h00; pa_oe <= 8'h00;
      pb_out <= 8'h00; pb_oe <= 8'h00;
      pc_out <= 8'h00; pc_oe <= 8'h00;
      pd_out <= 8'h00; pd_oe <= 8'h00;
      bus_rdata <= 8'h00;
    end else begin
      // port a: in-only 0..2, two-way 3 and 7, out-only 4..6
      pa_out <= {pa_gpio_out[7],
                 tmr_cmp_en[3:1] & tmr_cmp_out[3:1] | ~tmr_cmp_en[3:1] & pa_gpio_out[6:4],
                 tmr_cmp_en[0] ? tmr_cmp_out[0] : pa_gpio_out[3], 3'h0};
      pa_oe  <= {pa_gpio_dir[1], 3'h7, pa_gpio_dir[0] | tmr_cmp_en[0], 3'h0};
      if (bus_mode) begin
        pb_out <= bus_addr[15:8];
        pb_oe  <= 8'hFF;
        pc_out <= addr_phase ? bus_addr[7:0] : bus_wdata;
        pc_oe  <= (addr_phase || !bus_read) ? 8'hFF : 8'h00;
        if (div_q == 2'h3 && bus_read) bus_rdata <= pc_in; // paced by our own bus clock, no filter
        pd_out[7] <= bus_read;
        pd_out[6] <= (div_q == 2'h3);                   // first low phase
        pd_oe[7:6] <= 2'h3;
      end else begin
        pb_out <= pb_gpio_out; pb_oe <= pb_gpio_dir;
        pc_out <= pc_gpio_out; pc_oe <= pc_gpio_dir;
        pd_out[7:6] <= pd_gpio_out[7:6];
        pd_oe[7:6]  <= pd_gpio_dir[7:6];
      end
      // port d 0..5 shared with serial and spi
      pd_out[5:0] <= (ser_oe & ser_out) | (~ser_oe & pd_gpio_out[5:0]);
      pd_oe[5:0]  <= ser_oe | pd_gpio_dir[5:0];
    end
  end

  // filtered pin levels returned to peripherals and gpio readers
  always @* begin
    tmr_capture_in    = pa_f_q[3:0];
    pulse_count_input = pa_f_q[`PMX_PA_PULSE];
    pb_gpio_in        = pb_f_q;
    pc_gpio_in        = pc_f_q;
    pd_gpio_in        = pd_f_q;
    ser_in            = pd_f_q[5:0];
  end

endmodule

// file: verification/pmx_ext_mem.sv
/*
  external memory on the multiplexed bus: latches the address on the
  strobe, stores writes and answers reads on port c.
  assumes registered port outputs of the mux and read direction high.
*/
`timescale 1ns/1ps

module pmx_ext_mem (
  input  wire        core_clk,
  input  wire        eclk_pin,
  input  wire [7:0]  pb_out,
  input  wire [7:0]  pc_out,
  input  wire [7:0]  pc_oe,
  input  wire [7:0]  pd_out,
  output logic [7:0] pc_in
);
  logic [15:0] addr_q;
  logic [7:0]  mem [0:255];

  // address caught while the strobe is high, data taken while the bus clock is high
  always @(posedge core_clk) begin
    if (pd_out[6]) addr_q <= {pb_out, pc_out};
    if (eclk_pin && !pd_out[7] && pc_oe == 8'hFF) mem[addr_q[7:0]] <= pc_out;
  end
  // released bus shows the inverse so stale data cannot pass
  always @* pc_in = (eclk_pin && pd_out[7] && pc_oe == 8'h00) ? mem[addr_q[7:0]] : ~pc_out;
endmodule

// file: verification/pmx_pin_mux_assertions.sv
/*
  checker for the pin mux block: timing relations on its ports.
  assumes binding to pmx_pin_mux and pmx_defines.vh on the include path.
*/
`timescale 1ns/1ps
`include "pmx_defines.vh"

module pmx_chk (
  input wire        core_clk,
  input wire        sys_rst_n,
  input wire        reset_pin_oe,
  input wire        clk_mon_fail,
  input wire        watchdog_fail,
  input wire        eclk_pin,
  input wire        eclk_fall,
  input wire        eclk_off_req,
  input wire        irq_pin_n,
  input wire        irq_edge_select_bit,
  input wire        irq_req,
  input wire        prog_active,
  input wire        prom_ce_n,
  input wire        x_mask_clear,
  input wire        x_mask_q,
  input wire [1:0]  mode_q,
  input wire        instr_first_cycle,
  input wire        instr_fetch_indicator_oe,
  input wire [15:0] bus_addr,
  input wire [7:0]  pb_out,
  input wire [7:0]  pb_oe
);
  // internal reset covers the async pin too, so one disable serves all
  default clocking @(posedge core_clk); endclocking
  default disable iff (!sys_rst_n);

  // fault flags pull the reset pin at once
  rst_pin_drive_a: assert property (reset_pin_oe == (clk_mon_fail | watchdog_fail))
    else $error("reset pin drive wrong");
  eclk_period_a: assert property ($rose(eclk_pin) && mode_q[0] |->
    ##1 eclk_pin ##1 !eclk_pin [*2] ##1 eclk_pin) else $error("bus clock period wrong");
  eclk_off_a: assert property (eclk_off_req && mode_q == `PMX_MODE_SINGLE |=> !eclk_pin)
    else $error("bus clock not stopped");
  irq_level_a: assert property ((!irq_edge_select_bit && !irq_pin_n) [*6] |-> irq_req)
    else $error("level interrupt missed");
  prom_ce_idle_a: assert property (!prog_active |=> prom_ce_n)
    else $error("prom enable outside programming");
  xmask_hold_a: assert property (x_mask_q && !x_mask_clear |=> x_mask_q)
    else $error("mask dropped without clear");
  mode_hold_a: assert property ($past(sys_rst_n, 2) |-> $stable(mode_q))
    else $error("mode changed outside reset");
  fetch_ind_a: assert property ($past(sys_rst_n) && $past(eclk_fall) |->
    instr_fetch_indicator_oe == $past(instr_first_cycle)) else $error("fetch indicator wrong");
  fetch_hold_a: assert property ($past(sys_rst_n) && !$past(eclk_fall) |->
    $stable(instr_fetch_indicator_oe)) else $error("fetch indicator moved mid cycle");
  addr_high_a: assert property (mode_q[0] && $past(mode_q[0]) |->
    pb_out == $past(bus_addr[15:8]) && pb_oe == 8'hFF) else $error("high address wrong");
endmodule

bind pmx_pin_mux pmx_chk chk_u (.*);

// file: verification/tb.sv
/*
  self-checking bench for the pin mux block with external memory model.
  assumes the checker is bound in and core_clk runs at 100 MHz.
*/
`timescale 1ns/1ps

module tb;
  logic core_clk, arst_n, reset_pin_in_n, clk_mon_fail, watchdog_fail, eclk_off_req, irq_pin_n;
  logic irq_edge_select_bit, irq_ack, prog_active, nonmaskable_int_pin, x_mask_clear, bus_read;
  logic mode_select_a, mode_select_b, instr_first_cycle, reset_pin_oe, sys_rst_n, eclk_pin;
  logic eclk_rise, eclk_fall, irq_req, prom_ce_n, nonmaskable_int_pin_req, x_mask_q, pulse_count_input;
  logic instr_fetch_indicator_oe;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, pa_in, pa_out, pa_oe, pa_gpio_out, pb_in, pb_out, pb_oe;
  logic [7:0]  pb_gpio_out, pb_gpio_dir, pb_gpio_in, pc_in, pc_out, pc_oe, pc_gpio_out, pat;
  logic [7:0]  pc_gpio_dir, pc_gpio_in, pd_in, pd_out, pd_oe, pd_gpio_out, pd_gpio_dir, dir;
  logic [7:0]  pd_gpio_in;
  logic [1:0]  mode_q, pa_gpio_dir;
  logic [4:0]  tmr_cmp_out, tmr_cmp_en;
  logic [3:0]  tmr_capture_in;
  logic [5:0]  ser_out, ser_oe, ser_in;
  int          n_errors, total_checks, i, m;

  // pin levels and gpio sources follow two patterns; reset pin is wired-and
  assign {pa_in, pb_in, pd_in, pa_gpio_out, pb_gpio_out, pc_gpio_out, pd_gpio_out} = {7{pat}};
  assign {pb_gpio_dir, pc_gpio_dir, pd_gpio_dir} = {3{dir}};
  assign {ser_out, ser_oe, tmr_cmp_out, tmr_cmp_en, pa_gpio_dir} = {~pat[5:0], dir[5:0], pat[4:0],
    dir[4:0], dir[1:0]};
  assign reset_pin_in_n = !reset_pin_oe;

  pmx_pin_mux dut_u (.*);
  pmx_ext_mem mem_u (.core_clk(core_clk), .eclk_pin(eclk_pin), .pb_out(pb_out), .pc_out(pc_out),
    .pc_oe(pc_oe),
    .pd_out(pd_out), .pc_in(pc_in));

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // inputs move 1 ns after the edge so sampling never races
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // mode pins stay stable across the whole reset
  task automatic do_reset(input logic b, input logic a);
    mode_select_b = b;
    mode_select_a = a;
    arst_n = 0;
    cyc(16);
    arst_n = 1;
    for (i = 0; i < 30 && sys_rst_n !== 1'b1; i++) cyc(1);
    if (i == 30) begin
      n_errors++;
      print_verdict();
    end
    cyc(4);
  endtask

  // one core bus request held across two bus clock periods
  task automatic bus_op(input logic rd, input logic [15:0] a, input logic [7:0] d);
    bus_read = rd;
    bus_addr = a;
    bus_wdata = d;
    cyc(8);
  endtask

  initial begin
    {clk_mon_fail, watchdog_fail, eclk_off_req, irq_edge_select_bit, irq_ack} = 0;
    {prog_active, x_mask_clear, instr_first_cycle, bus_read} = 0;
    {irq_pin_n, nonmaskable_int_pin} = 2'h3;
    {bus_addr, bus_wdata, pat, dir} = {16'h0000, 8'h00, 8'h3C, 8'hA5};
    n_errors = 0;
    total_checks = 0;
    for (m = 0; m < 4; m++) begin
      do_reset(m < 2, m[0]);
      chk(mode_q, m);
      chk(pb_oe, m[0] ? 8'hFF : dir);
      chk(pd_oe[7:6], m[0] ? 2'h3 : dir[7:6]);
      chk(pa_oe[2:0], 3'h0);
    end
    chk(pa_out, 8'h30);
    chk(pa_oe, 8'h78);
    chk(pd_out[5:0], 6'h19);
    chk(pd_oe[5:0], 6'h25);
    chk({ser_in, tmr_capture_in, pulse_count_input}, {6'h3C, 4'hC, 1'b0});
    chk(pd_gpio_in, pat);
    bus_op(1'b0, 16'h12C3, 8'h5A);
    bus_op(1'b1, 16'h12C3, 8'h00);
    chk(bus_rdata, 8'h5A);
    chk(pb_out, 8'h12);
    do_reset(1'b1, 1'b0);
    chk(x_mask_q, 1'b1);
    x_mask_clear = 1;
    cyc(1);
    x_mask_clear = 0;
    nonmaskable_int_pin = 0;
    cyc(8);
    chk({x_mask_q, nonmaskable_int_pin_req}, 2'h1);
    nonmaskable_int_pin = 1;
    chk(pb_gpio_in, pat);
    eclk_off_req = 1;
    cyc(2);
    for (m = 0; m < 8; m++) begin
      chk(eclk_pin, 1'b0);
      cyc(1);
    end
    eclk_off_req = 0;
    irq_pin_n = 0;
    cyc(8);
    chk(irq_req, 1'b1);
    irq_pin_n = 1;
    cyc(8);
    chk(irq_req, 1'b0);
    irq_edge_select_bit = 1;
    irq_pin_n = 0;
    cyc(8);
    irq_pin_n = 1;
    cyc(8);
    chk(irq_req, 1'b1);
    irq_ack = 1;
    cyc(1);
    irq_ack = 0;
    cyc(2);
    chk(irq_req, 1'b0);
    prog_active = 1;
    irq_pin_n = 0;
    cyc(8);
    chk(prom_ce_n, 1'b0);
    {prog_active, irq_pin_n} = 2'h1;
    for (i = 0; i < 4 && eclk_fall !== 1'b1; i++) cyc(1);
    if (i == 4) begin
      n_errors++;
      print_verdict();
    end
    chk({eclk_pin, eclk_rise}, 2'h2);
    instr_first_cycle = 1;
    cyc(1);
    chk({eclk_pin, instr_fetch_indicator_oe}, 2'h1);
    instr_first_cycle = 0;
    cyc(3);
    chk(instr_fetch_indicator_oe, 1'b1);
    cyc(1);
    chk(instr_fetch_indicator_oe, 1'b0);
    clk_mon_fail = 1;
    cyc(1);
    chk(reset_pin_oe, 1'b1);
    {clk_mon_fail, watchdog_fail} = 2'h1;
    cyc(8);
    chk(sys_rst_n, 1'b0);
    watchdog_fail = 0;
    cyc(12);
    chk({sys_rst_n, x_mask_q}, 2'h3);
    print_verdict();
  end
endmodule
